// ==== rtl/line_driver_diag_pkg.sv ====
// Purpose: Shared constants for the line driver loopback and pattern test block
// Assumes: One bit per pclk on the serial paths, APB register access
// Notes: Long figures derive from the clock rate and are overridable at the top
package line_driver_diag_pkg;

  // ******************************************************************
  // Clock and timing
  // ******************************************************************
  localparam int CLK_HZ = 25_000_000; // pclk rate
  localparam int ERR_WINDOW_MS = 100; // Error rate observation window
  localparam int ERR_PULSE_MS = 200; // Error lamp flash on test start
  localparam int ERR_WINDOW_CYC_DEF = ERR_WINDOW_MS * (CLK_HZ / 1000);
  localparam int ERR_PULSE_CYC_DEF = ERR_PULSE_MS * (CLK_HZ / 1000);
  localparam int CONT_ERR_MIN_DEF = 64; // Errors per window that mean continuous

  // ******************************************************************
  // Pattern generator and checker
  // ******************************************************************
  localparam int PRBS_LEN = 9; // Nine stages give a 511-bit sequence
  localparam int PRBS_TAP_A = 8; // Stage nine
  localparam int PRBS_TAP_B = 4; // Stage five
  localparam logic [8:0] PRBS_SEED = 9'h1ff; // Any non-zero start
  localparam logic [3:0] LOCK_BITS = 4'h9; // Good bits before comparing

  // ******************************************************************
  // APB register map
  // ******************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ERRCNT = 8'h08;
  localparam logic [4:0] CONFIG_RESET = 5'h00;
  localparam int CFG_ECHO_PERMIT = 0; // dte_echo_loop_permit
  localparam int CFG_FAR_PERMIT = 1; // dte_far_loop_permit
  localparam int CFG_AUTO_RESP = 2; // auto_far_loop_response
  localparam int CFG_IF_LO = 3; // Interface kind, two bits
  localparam int CFG_IF_HI = 4;
  localparam logic [1:0] IF_X21 = 2'h2;
  localparam logic [1:0] IF_G703 = 2'h3;

  // ******************************************************************
  // Synchronised pin vector positions
  // ******************************************************************
  localparam int N_PINS = 11;
  localparam int PIN_BTN_ECHO = 0;
  localparam int PIN_BTN_FAR = 1;
  localparam int PIN_BTN_RET = 2;
  localparam int PIN_BTN_PRBS = 3;
  localparam int PIN_DTE_ECHO = 4;
  localparam int PIN_DTE_FAR = 5;
  localparam int PIN_RTS = 6;
  localparam int PIN_TXD = 7;
  localparam int PIN_RXD = 8;
  localparam int PIN_SIG_OK = 9;
  localparam int PIN_LOOP_DET = 10;

  localparam logic MARK = 1'b1; // Idle data level, also the forced off level

  // Error lamp states
  typedef enum logic [1:0] {ERR_OFF, ERR_BLINK, ERR_SOLID} err_state_t;

endpackage : line_driver_diag_pkg

// ==== rtl/line_driver_loopback_bert.sv ====
// Purpose: Loopback control, pattern tester and indicators of a line driver
// Assumes: pclk is the serial bit clock; every pin input is asynchronous
// Notes: Buttons toggle their mode; options live in an APB config register
//
// The implementer's own choices: register access over APB and the address map.
module line_driver_loopback_bert #(
  parameter int ERR_WINDOW_CYC = line_driver_diag_pkg::ERR_WINDOW_CYC_DEF,
  parameter int ERR_PULSE_CYC = line_driver_diag_pkg::ERR_PULSE_CYC_DEF,
  parameter int CONT_ERR_MIN = line_driver_diag_pkg::CONT_ERR_MIN_DEF,
  parameter int ERRCNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [line_driver_diag_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_echo_loop_button,
  input wire logic far_unit_loop_button,
  input wire logic near_return_loop_button,
  input wire logic prbs_test_button,
  input wire logic dte_echo_loop_req,
  input wire logic dte_far_loop_req,
  input wire logic dte_rts,
  input wire logic dte_tx_data,
  input wire logic line_rx_data,
  input wire logic line_signal_ok,
  input wire logic line_loop_req_detect,
  output logic line_tx_data,
  output logic far_loop_request,
  output logic dte_rx_data,
  output logic dte_cts,
  output logic dte_dsr,
  output logic dte_dcd,
  output logic dte_test_ind,
  output logic led_diag,
  output logic led_dcd,
  output logic led_rts,
  output logic led_td,
  output logic led_rd,
  output logic led_err
);
  import line_driver_diag_pkg::*;

  localparam int WIN_W = $clog2(ERR_WINDOW_CYC + 1);
  localparam int PUL_W = $clog2(ERR_PULSE_CYC + 1);
  localparam int CNT_W = $clog2(CONT_ERR_MIN + 1);

  // ******************************************************************
  // Pin synchronisers and button edges
  // ******************************************************************
  logic [N_PINS-1:0] pin_raw; // Asynchronous pins gathered
  logic [N_PINS-1:0] pin_meta_reg; // First stage, read only by second
  logic [N_PINS-1:0] pin_s; // Second stage, safe to use
  logic [3:0] btn_prev_reg; // Button levels one cycle ago
  logic [3:0] btn_rise; // Press events
  logic [3:0] tgl_reg; // Toggled button modes

  assign pin_raw = {line_loop_req_detect, line_signal_ok, line_rx_data, dte_tx_data, dte_rts,
                    dte_far_loop_req, dte_echo_loop_req, prbs_test_button,
                    near_return_loop_button, far_unit_loop_button, line_echo_loop_button};
  assign btn_rise = pin_s[PIN_BTN_PRBS:PIN_BTN_ECHO] & ~btn_prev_reg;

  // Two flip-flops on every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= '0;
      pin_s <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_s <= pin_meta_reg;
    end
  end

  // Each press flips its mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_prev_reg <= '0;
      tgl_reg <= '0;
    end else begin
      btn_prev_reg <= pin_s[PIN_BTN_PRBS:PIN_BTN_ECHO];
      tgl_reg <= tgl_reg ^ btn_rise;
    end
  end

  // ******************************************************************
  // Mode selection
  // ******************************************************************
  logic [4:0] cfg_reg; // Option switches and interface kind
  logic pins_ok; // DTE loop pins usable on this interface
  logic echo_on, far_on, ret_on, prbs_on, any_mode;
  logic prbs_start; // Pattern test being switched on

  assign pins_ok = (cfg_reg[CFG_IF_HI:CFG_IF_LO] != IF_X21) &&
                   (cfg_reg[CFG_IF_HI:CFG_IF_LO] != IF_G703);
  assign echo_on = tgl_reg[PIN_BTN_ECHO] |
                   (pins_ok & cfg_reg[CFG_ECHO_PERMIT] & pin_s[PIN_DTE_ECHO]);
  assign far_on = tgl_reg[PIN_BTN_FAR] |
                  (pins_ok & cfg_reg[CFG_FAR_PERMIT] & pin_s[PIN_DTE_FAR]);
  assign ret_on = tgl_reg[PIN_BTN_RET] |
                  (cfg_reg[CFG_AUTO_RESP] & pin_s[PIN_LOOP_DET]);
  assign prbs_on = tgl_reg[PIN_BTN_PRBS];
  assign any_mode = echo_on | far_on | ret_on | prbs_on;
  assign prbs_start = btn_rise[PIN_BTN_PRBS] & ~tgl_reg[PIN_BTN_PRBS];

  // ******************************************************************
  // Pattern generator and checker
  // ******************************************************************
  logic [8:0] gen_reg; // Generator stages
  logic [8:0] chk_reg; // Last nine received bits
  logic [3:0] good_reg; // Good bits seen before lock
  logic locked_reg; // Checker in step with the stream
  logic rx_src; // Bit reaching the receiver
  logic predicted; // Expected next received bit
  logic bit_err; // One mismatch this cycle

  assign rx_src = echo_on ? line_tx_data : pin_s[PIN_RXD];
  assign predicted = chk_reg[PRBS_TAP_A] ^ chk_reg[PRBS_TAP_B];
  // Local loop or remote generator feeds the same checker
  assign bit_err = prbs_on & locked_reg & (rx_src != predicted);

  // Generator runs only during the test, reseeded on start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_reg <= PRBS_SEED;
    end else if (prbs_start) begin
      gen_reg <= PRBS_SEED;
    end else if (prbs_on) begin
      gen_reg <= {gen_reg[7:0], gen_reg[PRBS_TAP_A] ^ gen_reg[PRBS_TAP_B]};
    end
  end

  // Checker shifts the stream in and locks after enough good bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_reg <= '0;
      good_reg <= '0;
      locked_reg <= 1'b0;
    end else if (!prbs_on) begin
      good_reg <= '0;
      locked_reg <= 1'b0;
    end else begin
      chk_reg <= {chk_reg[7:0], rx_src};
      if (!locked_reg) begin
        good_reg <= (rx_src == predicted) ? good_reg + 4'h1 : '0;
        locked_reg <= (rx_src == predicted) && (good_reg == LOCK_BITS - 4'h1);
      end
    end
  end

  // ******************************************************************
  // Error lamp
  // ******************************************************************
  logic [WIN_W-1:0] win_cnt_reg; // Position inside the window
  logic [CNT_W-1:0] win_err_reg; // Errors inside the window
  logic [PUL_W-1:0] pulse_reg; // Start flash remaining
  logic blink_reg; // Blink phase
  err_state_t err_state_reg; // Error lamp mode
  logic win_end;

  assign win_end = (win_cnt_reg == WIN_W'(ERR_WINDOW_CYC - 1));

  // Window counting and error density classification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= '0;
      win_err_reg <= '0;
      blink_reg <= 1'b0;
      err_state_reg <= ERR_OFF;
    end else if (!prbs_on) begin
      win_cnt_reg <= '0;
      win_err_reg <= '0;
      err_state_reg <= ERR_OFF;
    end else if (win_end) begin
      win_cnt_reg <= '0;
      win_err_reg <= '0;
      blink_reg <= ~blink_reg;
      if (win_err_reg >= CNT_W'(CONT_ERR_MIN)) begin
        err_state_reg <= ERR_SOLID;
      end else if (win_err_reg != '0) begin
        err_state_reg <= ERR_BLINK;
      end else begin
        err_state_reg <= ERR_OFF;
      end
    end else begin
      win_cnt_reg <= win_cnt_reg + WIN_W'(1);
      if (bit_err && win_err_reg != CNT_W'(CONT_ERR_MIN)) begin
        win_err_reg <= win_err_reg + CNT_W'(1);
      end
    end
  end

  // Brief flash whenever the test starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= '0;
    end else if (prbs_start) begin
      pulse_reg <= PUL_W'(ERR_PULSE_CYC);
    end else if (pulse_reg != '0) begin
      pulse_reg <= pulse_reg - PUL_W'(1);
    end
  end

  logic err_lamp;
  always_comb begin
    case (err_state_reg)
      ERR_SOLID: err_lamp = 1'b1;
      ERR_BLINK: err_lamp = blink_reg;
      default: err_lamp = 1'b0;
    endcase
  end

  // ******************************************************************
  // Data paths, interface controls and lamps
  // ******************************************************************
  logic tx_next, dsr_next, dcd_next;

  assign tx_next = ret_on ? pin_s[PIN_RXD] :
                   prbs_on ? gen_reg[PRBS_TAP_A] : pin_s[PIN_TXD];
  assign dsr_next = ~ret_on;
  assign dcd_next = dsr_next & (echo_on | pin_s[PIN_SIG_OK]);

  // All interface and lamp outputs are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_data <= MARK;
      far_loop_request <= 1'b0;
      dte_rx_data <= MARK;
      dte_cts <= 1'b0;
      dte_dsr <= 1'b0;
      dte_dcd <= 1'b0;
      dte_test_ind <= 1'b0;
      led_diag <= 1'b0;
      led_dcd <= 1'b0;
      led_rts <= 1'b0;
      led_td <= 1'b0;
      led_rd <= 1'b0;
      led_err <= 1'b0;
    end else begin
      line_tx_data <= tx_next;
      far_loop_request <= far_on;
      dte_rx_data <= prbs_on ? MARK : rx_src;
      dte_cts <= ~prbs_on & ~ret_on;
      dte_dsr <= dsr_next;
      dte_dcd <= dcd_next;
      dte_test_ind <= any_mode;
      led_diag <= any_mode;
      led_dcd <= dcd_next | far_on;
      led_rts <= pin_s[PIN_RTS] | far_on | ret_on;
      led_td <= (tx_next != MARK) | far_on | ret_on;
      led_rd <= ~prbs_on & ((rx_src != MARK) | far_on);
      led_err <= prbs_on & ((pulse_reg != '0) | err_lamp);
    end
  end

  // ******************************************************************
  // APB slave
  // ******************************************************************
  logic [ERRCNT_W-1:0] errcnt_reg; // Saturating mismatch count
  logic sel_cfg, sel_sts, sel_cnt, mapped, wr_go;
  logic [31:0] rd_mux;

  assign sel_cfg = (paddr == OFF_CONFIG);
  assign sel_sts = (paddr == OFF_STATUS);
  assign sel_cnt = (paddr == OFF_ERRCNT);
  assign mapped = sel_cfg | sel_sts | sel_cnt;
  assign wr_go = psel & penable & pready & pwrite;
  assign rd_mux = sel_cfg ? 32'(cfg_reg) :
                  sel_sts ? 32'({err_state_reg, locked_reg, pins_ok,
                                 prbs_on, ret_on, far_on, echo_on}) :
                  sel_cnt ? 32'(errcnt_reg) : 32'h0000_0000;

  // One wait-free access phase: answer registered at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      cfg_reg <= CONFIG_RESET;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~mapped;
      end
      if (wr_go && sel_cfg) begin
        cfg_reg <= pwdata[4:0];
      end
    end
  end

  // Any write to the count clears it; a new error in that cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errcnt_reg <= '0;
    end else if (wr_go && sel_cnt) begin
      errcnt_reg <= ERRCNT_W'(bit_err);
    end else if (bit_err && errcnt_reg != '1) begin
      errcnt_reg <= errcnt_reg + ERRCNT_W'(1);
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  echo_route_a: assert property (echo_on && !prbs_on |=> dte_rx_data == $past(line_tx_data))
    else $error("echo loop does not feed transmit into receiver");
  echo_toggle_a: assert property (btn_rise[PIN_BTN_ECHO] |=> tgl_reg[0] != $past(tgl_reg[0]))
    else $error("echo button did not toggle the loop");
  far_request_a: assert property (far_on |=> far_loop_request)
    else $error("far loop request not sent");
  far_lamps_a: assert property (far_on |=> led_diag && led_dcd && led_rts && led_td &&
                                (led_rd || $past(prbs_on)))
    else $error("far loop lamps wrong");
  ret_route_a: assert property (ret_on |=> line_tx_data == $past(pin_s[PIN_RXD]))
    else $error("return loop does not resend line data");
  ret_lamps_a: assert property (ret_on |=> led_diag && led_rts && led_td && !dte_dsr)
    else $error("return loop lamps or data set ready wrong");
  auto_resp_a: assert property (cfg_reg[CFG_AUTO_RESP] && pin_s[PIN_LOOP_DET] |-> ret_on)
    else $error("auto response did not close the return loop");
  pin_gate_a: assert property (!pins_ok |-> echo_on == tgl_reg[0] && far_on == tgl_reg[1])
    else $error("loop pins acted on a disallowed interface");
  err_flash_a: assert property (prbs_start |=> ##1 led_err [*2])
    else $error("error lamp did not flash on test start");
  diag_lamp_a: assert property (##1 led_diag == $past(any_mode))
    else $error("diag lamp disagrees with test modes");
  prbs_force_a: assert property (prbs_on |=> dte_rx_data == MARK && !dte_cts)
    else $error("receive data or cts not forced off");
  lfsr_live_a: assert property (gen_reg != 9'h000)
    else $error("pattern generator stuck at zero");

endmodule : line_driver_loopback_bert

// ==== sim/far_end_model.sv ====
// Purpose: Far-end line driver model facing the block over the line pair
// Assumes: One bit per pclk on the line; carrier and loop request are levels
// Notes: Loops line data back while asked, else sends its pattern or a level
module far_end_model (
  input wire logic pclk,
  input wire logic line_tx_data,
  input wire logic far_loop_request,
  input wire logic gen_on,
  input wire logic const_lvl,
  input wire logic err_inj,
  input wire logic carrier_on,
  input wire logic loop_req_on,
  output logic line_rx_data,
  output logic line_signal_ok,
  output logic line_loop_req_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] lfsr_reg = 9'h1ff; // Remote pattern state, never zero
  logic next_bit; // Bit the remote puts on the line next
  // Closed loop wins, then own pattern, then a steady level
  assign next_bit = far_loop_request ? line_tx_data : gen_on ? lfsr_reg[8] : const_lvl;
  assign line_signal_ok = carrier_on; // Carrier seen on the pair
  assign line_loop_req_detect = loop_req_on;
  // ******************************************************************
  // Line transmitter, one bit a cycle, with optional bit flips
  // ******************************************************************
  always @(posedge pclk) begin
    lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
    line_rx_data <= next_bit ^ err_inj;
  end
endmodule : far_end_model

// ==== sim/line_driver_loopback_bert_bench.sv ====
// Purpose: Self-checking bench for the loopback and pattern test block
// Assumes: Short error windows set through parameters; far end is modelled
// Notes: Drivers note results in a queue; a monitor compares them
module line_driver_loopback_bert_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import line_driver_diag_pkg::*;
  localparam int WIN = 64; // Error window length in cycles
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr;
  logic [3:0] btn = 4'h0; // Echo, far, return, pattern buttons
  logic dte_echo_req = 1'b0, dte_far_req = 1'b0, dte_rts = 1'b0, dte_tx = 1'b1;
  logic line_rx, sig_ok, loop_det, line_tx, far_req, dte_rx, cts, dsr, dcd, test_ind;
  logic [5:0] led; // Diag, dcd, rts, td, rd, err lamps
  logic gen_on = 1'b0, lvl = 1'b1, err_inj = 1'b0, carrier_on = 1'b0, loop_req_on = 1'b0;
  logic rnd_on = 1'b1, tx_lvl = 1'b1, pin_req = 1'b0;
  logic [12:0] pins; // Output pins gathered for compares
  logic [63:0] exp_q[$]; // Mask in upper word, value in lower
  integer seed = 32'hb6ae;
  int error_cnt = 0, comparisons = 0, cyc = 0, err_per = 0;
  assign pins = {line_tx, far_req, dte_rx, cts, dsr, dcd, test_ind, led};
  initial forever #20 pclk = ~pclk;
  line_driver_loopback_bert #(.ERR_WINDOW_CYC(WIN), .ERR_PULSE_CYC(8), .CONT_ERR_MIN(4),
    .ERRCNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_echo_loop_button(btn[0]), .far_unit_loop_button(btn[1]),
    .near_return_loop_button(btn[2]), .prbs_test_button(btn[3]),
    .dte_echo_loop_req(dte_echo_req), .dte_far_loop_req(dte_far_req), .dte_rts(dte_rts),
    .dte_tx_data(dte_tx), .line_rx_data(line_rx), .line_signal_ok(sig_ok),
    .line_loop_req_detect(loop_det), .line_tx_data(line_tx), .far_loop_request(far_req),
    .dte_rx_data(dte_rx), .dte_cts(cts), .dte_dsr(dsr), .dte_dcd(dcd),
    .dte_test_ind(test_ind), .led_diag(led[5]), .led_dcd(led[4]), .led_rts(led[3]),
    .led_td(led[2]), .led_rd(led[1]), .led_err(led[0]));
  far_end_model far_end (.pclk(pclk), .line_tx_data(line_tx), .far_loop_request(far_req),
    .gen_on(gen_on), .const_lvl(lvl), .err_inj(err_inj), .carrier_on(carrier_on),
    .loop_req_on(loop_req_on), .line_rx_data(line_rx), .line_signal_ok(sig_ok),
    .line_loop_req_detect(loop_det));
  // ******************************************************************
  // Free stimulus, error injection and hang guard
  // ******************************************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    dte_tx <= rnd_on ? $random(seed) % 2 != 0 : tx_lvl;
    err_inj <= err_per != 0 && cyc % err_per == 0;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // Monitor: takes the oldest note whenever a result shows
  always @(posedge pclk) begin
    logic [63:0] nt;
    logic [31:0] act;
    if ((psel && penable && pready === 1'b1) || pin_req) begin
      act = pin_req ? {19'h0, pins} : {prdata[31] | pslverr, prdata[30:0]};
      nt = exp_q.size() > 0 ? exp_q.pop_front() : 64'h0;
      comparisons++;
      if ((act & nt[63:32]) !== (nt[31:0] & nt[63:32])) begin
        error_cnt++;
        $display("BAD t=%0t exp=%h act=%h", $time, nt[31:0], act);
      end
    end
  end
  // APB transfer: setup, access until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m, e);
    exp_q.push_back({m, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0000_0000, m, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h8000_0000, 32'h0000_0000);
  endtask : wr
  // Pin compare at the next edge
  task automatic chk(input logic [12:0] m, e);
    exp_q.push_back({19'h0, m, 19'h0, e});
    pin_req <= 1'b1;
    @(posedge pclk);
    pin_req <= 1'b0;
    @(posedge pclk);
  endtask : chk
  task automatic press(input int i);
    btn[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    btn[i] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : press
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    logic [31:0] w;
    logic [15:0] tbl[9] = '{16'h0000, 16'h0101, 16'h0212, 16'h0110, 16'h1100, 16'h1a10,
      16'h0a12, 16'h0424, 16'h0020}; // Config, pin, expected modes
    presetn <= 1'b0; // Falling edge resets the block before the first clock
    chk(13'h1fff, 13'h1400); // Reset levels
    presetn <= 1'b1;
    rd(OFF_ERRCNT, 32'hffff_ffff, 32'h0000_0000);
    w = $random(seed);
    wr(OFF_CONFIG, w);
    rd(OFF_CONFIG, 32'hffff_ffff, {27'h0, w[4:0]});
    apb(1'b1, OFF_STATUS, 32'hffff_ffff, 32'h8000_0000, 32'h0000_0000);
    rd(OFF_STATUS, 32'h8000_000f, 32'h0000_0000);
    apb(1'b1, 8'h0c, 32'h0000_0001, 32'h8000_0000, 32'h8000_0000);
    rd(8'h0c, 32'hffff_ffff, 32'h8000_0000);
    wr(OFF_CONFIG, 32'h0000_0000);
    $display("Test registers done");
    rnd_on <= 1'b0;
    tx_lvl <= 1'b0;
    press(0);
    chk(13'h04f0, 13'h00f0);
    rd(OFF_STATUS, 32'h0000_000f, 32'h0000_0001);
    press(0);
    chk(13'h04f0, 13'h0400);
    carrier_on <= 1'b1;
    press(1);
    chk(13'h0c3e, 13'h083e);
    tx_lvl <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(13'h0c3e, 13'h0c3e);
    press(1);
    chk(13'h0800, 13'h0000);
    lvl <= 1'b0;
    press(2);
    chk(13'h112c, 13'h002c);
    lvl <= 1'b1;
    tx_lvl <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(13'h1000, 13'h1000);
    press(2);
    $display("Test loops done");
    foreach (tbl[i]) begin
      wr(OFF_CONFIG, {24'h0, tbl[i][15:8]});
      dte_echo_req <= tbl[i][7:4] == 4'h0;
      dte_far_req <= tbl[i][7:4] == 4'h1;
      loop_req_on <= tbl[i][7:4] == 4'h2;
      repeat (6) @(posedge pclk);
      rd(OFF_STATUS, 32'h0000_0007, {28'h0, tbl[i][3:0]});
      dte_echo_req <= 1'b0;
      dte_far_req <= 1'b0;
      loop_req_on <= 1'b0;
      repeat (6) @(posedge pclk);
    end
    wr(OFF_CONFIG, 32'h0000_0000);
    $display("Test pins done");
    rnd_on <= 1'b1;
    press(0);
    press(3);
    chk(13'h0621, 13'h0421);
    repeat (40) @(posedge pclk);
    wr(OFF_ERRCNT, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    rd(OFF_ERRCNT, 32'h0000_ffff, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_00ef, 32'h0000_0029);
    press(0);
    press(1);
    err_per <= 16;
    repeat (200) @(posedge pclk);
    rd(OFF_STATUS, 32'h0000_00c0, 32'h0000_0080);
    chk(13'h0001, 13'h0001);
    err_per <= WIN;
    repeat (200) @(posedge pclk);
    rd(OFF_STATUS, 32'h0000_00c0, 32'h0000_0040);
    err_per <= 0;
    repeat (200) @(posedge pclk);
    rd(OFF_STATUS, 32'h0000_00c0, 32'h0000_0000);
    chk(13'h0001, 13'h0000);
    press(1);
    gen_on <= 1'b1;
    repeat (40) @(posedge pclk);
    wr(OFF_ERRCNT, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    rd(OFF_ERRCNT, 32'h0000_ffff, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_002f, 32'h0000_0028);
    $display("Test pattern done");
    repeat (2) @(posedge pclk);
    test_done();
  end
endmodule : line_driver_loopback_bert_bench
